// >>> src/msp_pkg.sv
// Package for the module system power control block: timing constants,
// power states and core-side request and status bundles.
// Assumes a single 200 MHz core clock.
package msp_pkg;

  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned DEBOUNCE_MS      = 4;
  localparam int unsigned DEBOUNCE_CYCLES  = DEBOUNCE_MS * 1000 * CLK_MHZ;
  localparam int unsigned PG_STABLE_MS     = 10;
  localparam int unsigned PG_STABLE_CYCLES = PG_STABLE_MS * 1000 * CLK_MHZ;
  localparam int unsigned RESET_PULSE_US   = 1;
  localparam int unsigned RESET_PULSE_CYCLES = RESET_PULSE_US * CLK_MHZ;
  localparam int unsigned CNT_W            = 24;
  localparam int unsigned GEN_PINS         = 4;
  localparam logic [3:0]  GEN_RESET_OE     = 4'h0;
  localparam logic [3:0]  GEN_RESET_OUT    = 4'h0;

  typedef enum logic [2:0] {
    MSP_OFF      = 3'b000,
    MSP_WAIT_PG  = 3'b001,
    MSP_RESET    = 3'b010,
    MSP_RUN      = 3'b011,
    MSP_SLEEP    = 3'b100
  } msp_state_t;

  // Requests from the processor core side
  typedef struct packed {
    logic       sleep_req;
    logic       off_req;
    logic       wdog_expire;
    logic [3:0] gen_oe;
    logic [3:0] gen_out;
  } msp_core_req_t;

  // Status towards the processor core side
  typedef struct packed {
    logic       button_event;
    logic       wake_event;
    logic       load_defaults;
    logic       firmware_hub_off;
    logic [3:0] gen_in;
  } msp_core_stat_t;

endpackage : msp_pkg

// >>> src/msp_power_ctrl.sv
// Power sequencer and system-control pin logic of the module.
// Assumes baseboard pins are asynchronous; core requests are on core_clk.
`timescale 1ns/1ps

// Notes on behaviour
// - A low power button pin counts as a press.
// - A low wake pin counts as a wake request.
// - A low reset input holds the module in its reset cycle.
// - Reset output is low during every reset cycle, released after.
// - supply_switch_on high turns on the baseboard supplies.
// - Low load-defaults pin at power-on makes firmware load setup defaults.
// - Low firmware-disable pin disables the onboard firmware hub.
// - watchdog_expired goes high on a watchdog timeout.
// - watchdog_expired is cleared at power-up and every reset.
// - sleep_state_n is low in S3, high otherwise.
// - suspend_state_n is low in S4/S5, high otherwise.
// - Four general pins, each input or output.
module msp_power_ctrl #(
  parameter int unsigned DEBOUNCE_CNT  = msp_pkg::DEBOUNCE_CYCLES,
  parameter int unsigned PG_STABLE_CNT = msp_pkg::PG_STABLE_CYCLES
) (
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  input  wire logic                    power_button_n,
  input  wire logic                    wake_n,
  input  wire logic                    reset_in_n,
  input  wire logic                    supplies_valid,
  input  wire logic                    load_defaults_n,
  input  wire logic                    firmware_hub_disable_n,
  input  wire logic [3:0]              gen_pin_in,
  input  wire msp_pkg::msp_core_req_t  core_req,
  output logic                         reset_out_n,
  output logic                         supply_switch_on,
  output logic                         watchdog_expired,
  output logic                         sleep_state_n,
  output logic                         suspend_state_n,
  output logic [3:0]                   gen_pin_out,
  output logic [3:0]                   gen_pin_oe,
  output msp_pkg::msp_core_stat_t      core_stat
);
  import msp_pkg::*;

  // Debounced level follows the synced input only after it has held steady
  function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] c, input logic hold);
    cnt_step = hold ? (c + 1'b1) : '0;
  endfunction : cnt_step

  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [2:0] deb_q;
  logic [2:0] deb_prev_q;
  logic [CNT_W-1:0] dcnt_q [3];
  logic [3:0] gen_s1_q;
  logic [3:0] gen_s2_q;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s1_q <= 4'hf;
      s2_q <= 4'hf;
      gen_s1_q <= 4'h0;
      gen_s2_q <= 4'h0;
    end else begin
      s1_q <= {supplies_valid, reset_in_n, wake_n, power_button_n};
      s2_q <= s1_q;
      gen_s1_q <= gen_pin_in;
      gen_s2_q <= gen_s1_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      deb_q <= 3'h7;
      deb_prev_q <= 3'h7;
      for (int i = 0; i < 3; i++) dcnt_q[i] <= '0;
    end else begin
      deb_prev_q <= deb_q;
      for (int i = 0; i < 3; i++) begin
        if (s2_q[i] == deb_q[i]) begin
          dcnt_q[i] <= '0;
        end else if (dcnt_q[i] >= CNT_W'(DEBOUNCE_CNT - 1)) begin
          dcnt_q[i] <= '0;
          deb_q[i] <= s2_q[i];
        end else begin
          dcnt_q[i] <= cnt_step(dcnt_q[i], 1'b1);
        end
      end
    end
  end

  logic btn_press;
  logic wake_req;
  logic rst_in_act;
  logic pg_sync;
  // Press on falling edge of the filtered button
  assign btn_press  = deb_prev_q[0] & ~deb_q[0];
  // Wake on falling edge of the filtered wake pin
  assign wake_req   = deb_prev_q[1] & ~deb_q[1];
  assign rst_in_act = ~deb_q[2];
  assign pg_sync    = s2_q[3];

  msp_state_t state_q;
  logic [CNT_W-1:0] pg_cnt_q;
  logic [CNT_W-1:0] rst_cnt_q;
  logic off_s3_q;

  // Power state sequencing
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= MSP_OFF;
      pg_cnt_q <= '0;
      rst_cnt_q <= '0;
      off_s3_q <= 1'b0;
    end else begin
      unique case (state_q)
        MSP_OFF: begin
          pg_cnt_q <= '0;
          if (btn_press || wake_req) state_q <= MSP_WAIT_PG;
        end
        MSP_WAIT_PG: begin
          pg_cnt_q <= cnt_step(pg_cnt_q, pg_sync);
          if (pg_sync && pg_cnt_q >= CNT_W'(PG_STABLE_CNT - 1)) begin
            state_q <= MSP_RESET;
            rst_cnt_q <= '0;
          end
        end
        // Reset cycle holds while the reset input is low, then lasts RESET_PULSE_CYCLES more
        MSP_RESET: begin
          if (!pg_sync) begin
            state_q <= MSP_WAIT_PG;
            pg_cnt_q <= '0;
          end else if (rst_in_act) begin
            rst_cnt_q <= '0;
          end else if (rst_cnt_q >= CNT_W'(RESET_PULSE_CYCLES - 1)) begin
            state_q <= MSP_RUN;
          end else begin
            rst_cnt_q <= cnt_step(rst_cnt_q, 1'b1);
          end
        end
        MSP_RUN: begin
          rst_cnt_q <= '0;
          if (!pg_sync) begin
            state_q <= MSP_WAIT_PG;
            pg_cnt_q <= '0;
          end else if (rst_in_act) begin
            state_q <= MSP_RESET;
          end else if (core_req.off_req || btn_press) begin
            state_q <= MSP_OFF;
          end else if (core_req.sleep_req) begin
            state_q <= MSP_SLEEP;
          end
        end
        MSP_SLEEP: begin
          if (btn_press || wake_req) begin
            state_q <= MSP_WAIT_PG;
            pg_cnt_q <= '0;
          end else if (core_req.off_req) begin
            state_q <= MSP_OFF;
          end
        end
        default: state_q <= MSP_OFF;
      endcase
    end
  end

  // Reset output low outside the running state
  always_ff @(posedge core_clk) begin
    if (reset) reset_out_n <= 1'b0;
    else       reset_out_n <= (state_q == MSP_RUN) && !rst_in_act && pg_sync;
  end

  // Supplies on except in soft-off and sleep
  always_ff @(posedge core_clk) begin
    if (reset) supply_switch_on <= 1'b0;
    else supply_switch_on <= (state_q == MSP_WAIT_PG) || (state_q == MSP_RESET) || (state_q == MSP_RUN);
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sleep_state_n <= 1'b1;
      suspend_state_n <= 1'b0;
    end else begin
      sleep_state_n <= (state_q != MSP_SLEEP);
      suspend_state_n <= (state_q != MSP_OFF);
    end
  end

  // Watchdog flag; set holds until a reset cycle clears it
  always_ff @(posedge core_clk) begin
    if (reset) watchdog_expired <= 1'b0;
    else if (core_req.wdog_expire) watchdog_expired <= 1'b1;
    else if (state_q == MSP_RESET) watchdog_expired <= 1'b0;
  end

  // Boot straps, captured in every state except MSP_RUN
  logic ld_s1_q, ld_s2_q, fd_s1_q, fd_s2_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ld_s1_q <= 1'b1;
      ld_s2_q <= 1'b1;
      fd_s1_q <= 1'b1;
      fd_s2_q <= 1'b1;
    end else begin
      ld_s1_q <= load_defaults_n;
      ld_s2_q <= ld_s1_q;
      fd_s1_q <= firmware_hub_disable_n;
      fd_s2_q <= fd_s1_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      gen_pin_oe  <= GEN_RESET_OE;
      gen_pin_out <= GEN_RESET_OUT;
      core_stat   <= '0;
    end else begin
      gen_pin_oe  <= core_req.gen_oe;
      gen_pin_out <= core_req.gen_out;
      core_stat.button_event <= btn_press;
      core_stat.wake_event   <= wake_req;
      core_stat.gen_in       <= gen_s2_q;
      if (state_q != MSP_RUN) begin
        core_stat.load_defaults    <= ~ld_s2_q;
        core_stat.firmware_hub_off <= ~fd_s2_q;
      end
    end
  end

  // Reset output held low while in the reset state
  rst_low_a: assert property (@(posedge core_clk) disable iff (reset)
    state_q == MSP_RESET |=> !reset_out_n) else $error("reset_out_n high during reset cycle");

  pg_release_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(reset_out_n) |-> $past(pg_sync)) else $error("reset released without supplies_valid");

  // Supplies requested while waiting for power good
  supply_on_a: assert property (@(posedge core_clk) disable iff (reset)
    state_q == MSP_WAIT_PG |=> supply_switch_on) else $error("supply_switch_on low while waiting");

  wdog_set_a: assert property (@(posedge core_clk) disable iff (reset)
    core_req.wdog_expire |=> watchdog_expired) else $error("watchdog flag not set");

  wdog_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    state_q == MSP_RESET && !core_req.wdog_expire |=> !watchdog_expired) else $error("watchdog flag not cleared");

  sleep_ind_a: assert property (@(posedge core_clk) disable iff (reset)
    state_q == MSP_SLEEP |=> !sleep_state_n) else $error("sleep_state_n high in sleep");

  susp_ind_a: assert property (@(posedge core_clk) disable iff (reset)
    state_q == MSP_OFF |=> !suspend_state_n) else $error("suspend_state_n high in off");

  // Reset input forces the reset cycle
  rst_in_a: assert property (@(posedge core_clk) disable iff (reset)
    state_q == MSP_RUN && rst_in_act && pg_sync |=> state_q == MSP_RESET) else $error("reset input ignored");

  btn_on_a: assert property (@(posedge core_clk) disable iff (reset)
    state_q == MSP_OFF && btn_press |=> state_q == MSP_WAIT_PG) else $error("button press ignored");

  gen_oe_a: assert property (@(posedge core_clk) disable iff (reset)
    1'b1 |=> gen_pin_oe == $past(core_req.gen_oe)) else $error("gen_pin_oe mismatch");

endmodule : msp_power_ctrl

// >>> dv/msp_board_model.sv
// Baseboard model: a supply that reports good some cycles after switch-on,
// and the general pins as wires. Assumes module outputs change on core_clk.
`timescale 1ns/1ps
module msp_board_model #(
  parameter int PG_DELAY = 5
) (
  input  wire logic       core_clk,
  input  wire logic       supply_switch_on,
  input  wire logic [3:0] gen_pin_out,
  input  wire logic [3:0] gen_pin_oe,
  input  wire logic [3:0] board_gen,
  output logic            supplies_valid,
  output logic [3:0]      gen_pin_in
);
  int cnt_q = 0;

  always_ff @(posedge core_clk) begin
    cnt_q <= supply_switch_on ? cnt_q + 1 : 0;
    supplies_valid <= supply_switch_on && (cnt_q >= PG_DELAY);
  end

  assign gen_pin_in = (gen_pin_oe & gen_pin_out) | (~gen_pin_oe & board_gen);
endmodule : msp_board_model

// >>> dv/module_system_power_control_tb.sv
// Testbench for the power sequencer with the baseboard model on its pins.
// Assumes shortened debounce and supply-stable counts to keep the run short.
`timescale 1ns/1ps
module module_system_power_control_tb;
  import msp_pkg::*;
  localparam int PG = 8;
  logic           core_clk = 0;
  logic           reset = 1;
  logic           power_button_n = 1;
  logic           wake_n = 1;
  logic           reset_in_n = 1;
  logic           load_defaults_n = 1;
  logic           firmware_hub_disable_n = 1;
  logic [3:0]     board_gen = 4'h0;
  logic [3:0]     gen_pin_in, gen_pin_out, gen_pin_oe, exp_in;
  logic           supplies_valid, reset_out_n, supply_switch_on;
  logic           watchdog_expired, sleep_state_n, suspend_state_n;
  msp_core_req_t  core_req = '0;
  msp_core_stat_t core_stat;
  int             failures = 0, comparisons = 0, cycles = 0;
  int             seed = 64145, mst = 0, i, t0;
  int             btn_ev = 0, wake_ev = 0;

  msp_power_ctrl #(.DEBOUNCE_CNT(4), .PG_STABLE_CNT(PG)) msp_power_ctrl_inst (
    .core_clk(core_clk), .reset(reset), .power_button_n(power_button_n),
    .wake_n(wake_n), .reset_in_n(reset_in_n), .supplies_valid(supplies_valid),
    .load_defaults_n(load_defaults_n), .firmware_hub_disable_n(firmware_hub_disable_n),
    .gen_pin_in(gen_pin_in), .core_req(core_req), .reset_out_n(reset_out_n),
    .supply_switch_on(supply_switch_on), .watchdog_expired(watchdog_expired),
    .sleep_state_n(sleep_state_n), .suspend_state_n(suspend_state_n),
    .gen_pin_out(gen_pin_out), .gen_pin_oe(gen_pin_oe), .core_stat(core_stat));

  msp_board_model msp_board_model_inst (
    .core_clk(core_clk), .supply_switch_on(supply_switch_on), .gen_pin_out(gen_pin_out),
    .gen_pin_oe(gen_pin_oe), .board_gen(board_gen), .supplies_valid(supplies_valid),
    .gen_pin_in(gen_pin_in));

  always #2.5 core_clk = ~core_clk;

  // A hung sequence must still end in the report
  always @(posedge core_clk) begin
    cycles++;
    // Event outputs are one-cycle pulses, so count them edge by edge
    if (core_stat.button_event === 1'b1) btn_ev++;
    if (core_stat.wake_event === 1'b1) wake_ev++;
    if (cycles == 5000) begin
      failures++;
      close_out();
    end
  end

  task automatic close_out();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Model state: 0 off, 1 running, 2 sleeping
  task automatic chk_state();
    chk("sleep_state_n", 8'(mst != 2), 8'(sleep_state_n));
    chk("suspend_state_n", 8'(mst != 0), 8'(suspend_state_n));
  endtask : chk_state

  // Sample mid-cycle so the edge's updates have landed
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic pulse(input int which, input int n);
    @(posedge core_clk);
    case (which)
      0: power_button_n <= 1'b0;
      1: wake_n <= 1'b0;
      default: reset_in_n <= 1'b0;
    endcase
    repeat (n) @(posedge core_clk);
    power_button_n <= 1'b1;
    wake_n <= 1'b1;
    reset_in_n <= 1'b1;
  endtask : pulse

  task automatic req(input int which);
    @(posedge core_clk);
    core_req.sleep_req <= (which == 0);
    core_req.off_req <= (which == 1);
    core_req.wdog_expire <= (which == 2);
    @(posedge core_clk);
    core_req.sleep_req <= 1'b0;
    core_req.off_req <= 1'b0;
    core_req.wdog_expire <= 1'b0;
    cyc(3);
  endtask : req

  task automatic boot(input int min);
    for (i = 0; i < 40 && supply_switch_on !== 1'b1; i++) cyc(1);
    chk("supply_switch_on", 8'h01, 8'(supply_switch_on));
    for (i = 0; i < 40 && supplies_valid !== 1'b1; i++) cyc(1);
    t0 = cycles;
    for (i = 0; i < 600 && reset_out_n !== 1'b1; i++) cyc(1);
    chk("reset_release", 8'h01, 8'(reset_out_n === 1'b1 && cycles - t0 >= min));
    mst = 1;
    chk_state();
  endtask : boot

  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    cyc(2);
    chk("reset_out_n", 8'h00, 8'(reset_out_n));
    chk("watchdog_expired", 8'h00, 8'(watchdog_expired));
    chk_state();
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      load_defaults_n <= k[0];
      firmware_hub_disable_n <= k[1];
      cyc(6);
      chk("load_defaults", 8'(!k[0]), 8'(core_stat.load_defaults));
      chk("firmware_hub_off", 8'(!k[1]), 8'(core_stat.firmware_hub_off));
    end
    pulse(0, 2);
    cyc(20);
    chk("glitch_ignored", 8'h00, 8'(supply_switch_on));
    pulse(0, 12);
    boot(PG + 200);
    $display("test power_on done");
    for (int k = 0; k < 6; k++) begin
      @(posedge core_clk);
      core_req.gen_oe <= 4'($random(seed));
      core_req.gen_out <= 4'($random(seed));
      board_gen <= 4'($random(seed));
      // One edge to the pin register, two to sync, one into core_stat
      cyc(5);
      exp_in = (core_req.gen_oe & core_req.gen_out) | (~core_req.gen_oe & board_gen);
      chk("gen_pin_oe", 8'(core_req.gen_oe), 8'(gen_pin_oe));
      chk("gen_pin_out", 8'(core_req.gen_out), 8'(gen_pin_out));
      chk("gen_in", 8'(exp_in), 8'(core_stat.gen_in));
    end
    $display("test gen_pins done");
    req(2);
    chk("watchdog_expired", 8'h01, 8'(watchdog_expired));
    pulse(2, 12);
    cyc(2);
    chk("reset_out_n", 8'h00, 8'(reset_out_n));
    chk("watchdog_expired", 8'h00, 8'(watchdog_expired));
    boot(200);
    $display("test watchdog_reset done");
    req(0);
    mst = 2;
    chk_state();
    pulse(1, 12);
    boot(200);
    $display("test sleep_wake done");
    req(1);
    mst = 0;
    chk_state();
    chk("supply_switch_on", 8'h00, 8'(supply_switch_on));
    $display("test power_off done");
    chk("button_event", 8'h01, 8'(btn_ev));
    chk("wake_event", 8'h01, 8'(wake_ev));
    close_out();
  end
endmodule : module_system_power_control_tb
